/* design/gsrc_defs.svh */
// constants for the gain step and read-back control block
// assumes inclusion by bare name from the package; the design files see its macros through that include
`ifndef GSRC_DEFS_SVH
`define GSRC_DEFS_SVH

`define GSRC_REG_CTRL 8'h00
`define GSRC_REG_STATUS 8'h04
`define GSRC_REG_GAIN_A 8'h08
`define GSRC_REG_GAIN_B 8'h0C
`define GSRC_CTRL_RESET 2'h3
`define GSRC_ST_ARMED_LSB 8
`define GSRC_ST_MODE_LSB 12
`define GSRC_GAIN_DB_LSB 8

`define GSRC_IFACE_SERIAL 2'h1
`define GSRC_CODE_MIN_GAIN 6'h3F
`define GSRC_CODE_MAX_GAIN 6'h00
`define GSRC_CODE_FLOOR 6'h23
`define GSRC_GAIN_TOP_DB 8'h1A
`define GSRC_GAIN_FLOOR_DB 8'hF7

`define GSRC_SPI_BITS 5'h10
`define GSRC_SPI_RW_BIT 8
`define GSRC_SPI_GAIN_MSB 7
`define GSRC_SPI_GAIN_LSB 2
`define GSRC_SPI_FA_MSB 1

`endif

/* design/gsrc_pkg.sv */
// types shared by the gain step and read-back control block
// assumes the constants header sits beside it
package gsrc_pkg;
  `include "gsrc_defs.svh"

  typedef logic [5:0] gsrc_code_t;

  // gray along idle -> write and idle -> read
  typedef enum logic [1:0] {
    GSRC_SER_IDLE = 2'b00,
    GSRC_SER_WR = 2'b01,
    GSRC_SER_RD = 2'b10
  } gsrc_ser_state_t;
endpackage

/* design/gsrc_sync.sv */
// two flip-flop synchroniser, one chain per bit
// assumes every input bit is asynchronous to i_clk
`timescale 1ns/1ps
module gsrc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic [W-1:0] i_async, // pin levels
  output logic [W-1:0] o_sync // synchronised levels
);
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= i_async[b];
          sync_q <= meta_q;
        end
      end
      assign o_sync[b] = sync_q;
    end
  endgenerate
endmodule

/* design/gsrc_top.sv */
// gain code keeper for two channels: up/down stepping, serial read-back, wishbone regs
// assumes all pins are asynchronous and slow against the 125 MHz i_clk
// Function
// - direction low pulse lowers code one step
// - direction high pulse raises code one step
// - direction change within pulse means reset
// - reset loads all ones code, minimum gain
// - step size 1,2,4,8 from select pins
// - code saturates at both range ends
// - code zero is +26 dB, floor -9
// - read-back only in serial interface mode
// - read cycle only after armed write cycle
// - read data changes on serial clock rise
// - each read needs a fresh arming write
// - data pin driven only in read cycle
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module gsrc_top
  import gsrc_pkg::*;
(
  input wire logic i_clk, // 125 MHz system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_wb_cyc, // wishbone cycle
  input wire logic i_wb_stb, // wishbone strobe
  input wire logic i_wb_we, // wishbone write enable
  input wire logic [7:0] i_wb_adr, // wishbone byte address
  input wire logic [31:0] i_wb_dat, // wishbone write data
  input wire logic [3:0] i_wb_sel, // wishbone byte selects
  output logic [31:0] o_wb_dat, // wishbone read data
  output logic o_wb_ack, // wishbone acknowledge
  input wire logic [1:0] i_step_pulse_clock, // step pulse per channel
  input wire logic [1:0] i_step_direction, // step direction per channel
  input wire logic i_step_size_select_hi, // step size select high
  input wire logic i_step_size_select_lo, // step size select low
  input wire logic i_iface_select_hi, // interface select high
  input wire logic i_iface_select_lo, // interface select low
  input wire logic i_chan_a_select_n, // serial select channel a, low
  input wire logic i_chan_b_select_n, // serial select channel b, low
  input wire logic i_serial_clock, // serial clock
  input wire logic i_serial_data, // serial data pin level in
  output logic o_serial_data, // serial data pin level out
  output logic o_serial_data_oe_n, // low while driving data pin
  output logic [5:0] o_gain_code_a, // channel a gain code
  output logic [5:0] o_gain_code_b, // channel b gain code
  output logic [7:0] o_gain_db_a, // channel a gain, signed dB
  output logic [7:0] o_gain_db_b // channel b gain, signed dB
);
  logic [11:0] pins_sync;
  logic [1:0] pclk_s, pclk_p_q, dir_s;
  logic gs_hi_s, gs_lo_s, md_hi_s, md_lo_s;
  logic csa_n_s, csb_n_s, sclk_s, sdi_s, sclk_p_q;
  logic sclk_rise, serial_mode, updn_mode;
  logic [5:0] step_amt;
  logic [1:0] rst_evt, ser_wr;
  gsrc_code_t ser_code;
  gsrc_code_t code_all [2];
  logic [7:0] db_all [2];
  gsrc_sync #(.W(12)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_iface_select_hi, i_iface_select_lo, i_step_size_select_hi,
              i_step_size_select_lo, i_step_direction, i_step_pulse_clock,
              i_chan_b_select_n, i_chan_a_select_n, i_serial_clock, i_serial_data}),
    .o_sync(pins_sync)
  );
  assign {md_hi_s, md_lo_s, gs_hi_s, gs_lo_s, dir_s, pclk_s,
          csb_n_s, csa_n_s, sclk_s, sdi_s} = pins_sync;
  // mode 1x is stepping, 01 serial, 00 parallel (parallel not handled here)
  assign updn_mode = md_hi_s;
  assign serial_mode = ({md_hi_s, md_lo_s} == `GSRC_IFACE_SERIAL);
  assign step_amt = 6'h01 << {gs_hi_s, gs_lo_s};
  assign sclk_rise = sclk_s & ~sclk_p_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pclk_p_q <= 2'b00;
      sclk_p_q <= 1'b0;
    end else begin
      pclk_p_q <= pclk_s;
      sclk_p_q <= sclk_s;
    end
  end
  function automatic logic [7:0] gsrc_db(input gsrc_code_t c);
    if (c >= `GSRC_CODE_FLOOR) begin
      return `GSRC_GAIN_FLOOR_DB;
    end
    return `GSRC_GAIN_TOP_DB - {2'b00, c};
  endfunction
  // wishbone control register, read by the channel logic
  logic [1:0] step_en_q, step_en_d;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      gsrc_code_t code_q, code_d;
      logic [7:0] db_q, db_d;
      logic dirlat_q, dirlat_d;
      logic pend_q, pend_d;
      logic evt;
      logic p_rise, p_fall;

      assign p_rise = pclk_s[g] & ~pclk_p_q[g];
      assign p_fall = ~pclk_s[g] & pclk_p_q[g];

      always_comb begin
        code_d = code_q;
        dirlat_d = dirlat_q;
        pend_d = pend_q;
        evt = 1'b0;
        if (updn_mode && step_en_q[g]) begin
          if (p_rise) begin
            dirlat_d = dir_s[g];
            pend_d = 1'b1;
          end else if (p_fall && pend_q) begin
            pend_d = 1'b0;
            if (dir_s[g] != dirlat_q) begin
              code_d = `GSRC_CODE_MIN_GAIN;
              evt = 1'b1;
            end else if (!dir_s[g]) begin
              code_d = (code_q < step_amt) ? `GSRC_CODE_MAX_GAIN : code_q - step_amt;
            end else begin
              code_d = (code_q > (`GSRC_CODE_MIN_GAIN - step_amt)) ?
                       `GSRC_CODE_MIN_GAIN : code_q + step_amt;
            end
          end
        end else begin
          // a pulse cut by a mode change must not step later
          pend_d = 1'b0;
        end
        if (ser_wr[g]) begin
          code_d = ser_code;
        end
        db_d = gsrc_db(code_d);
      end

      // each channel owns its code; only its own pins and writes touch it
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          code_q <= `GSRC_CODE_MIN_GAIN;
          db_q <= `GSRC_GAIN_FLOOR_DB;
          dirlat_q <= 1'b0;
          pend_q <= 1'b0;
        end else begin
          code_q <= code_d;
          db_q <= db_d;
          dirlat_q <= dirlat_d;
          pend_q <= pend_d;
        end
      end

      assign rst_evt[g] = evt;
      assign code_all[g] = code_q;
      assign db_all[g] = db_q;
    end
  endgenerate
  assign o_gain_code_a = code_all[0];
  assign o_gain_code_b = code_all[1];
  assign o_gain_db_a = db_all[0];
  assign o_gain_db_b = db_all[1];
  // serial port
  gsrc_ser_state_t st_q, st_d;
  logic [4:0] bits_q, bits_d;
  logic [15:0] sh_q, sh_d;
  logic [1:0] chsel_q, chsel_d;
  logic rdch_q, rdch_d;
  logic [1:0] armed_q, armed_d;
  logic [1:0][1:0] fa_q, fa_d;
  logic sdo_q, sdo_d, oe_n_q, oe_n_d;
  logic [1:0] cs_now;

  assign cs_now = {~csb_n_s, ~csa_n_s};
  assign ser_code = sh_q[`GSRC_SPI_GAIN_MSB:`GSRC_SPI_GAIN_LSB];

  always_comb begin
    st_d = st_q;
    bits_d = bits_q;
    sh_d = sh_q;
    chsel_d = chsel_q;
    rdch_d = rdch_q;
    armed_d = armed_q;
    fa_d = fa_q;
    sdo_d = sdo_q;
    oe_n_d = oe_n_q;
    ser_wr = 2'b00;
    unique case (st_q)
      GSRC_SER_IDLE: begin
        oe_n_d = 1'b1;
        if (serial_mode && (cs_now != 2'b00)) begin
          chsel_d = cs_now;
          bits_d = 5'h00;
          sdo_d = 1'b0;
          // both selects low never reads: one data line, one channel at a time
          if (cs_now == 2'b01 && armed_q[0] || cs_now == 2'b10 && armed_q[1]) begin
            st_d = GSRC_SER_RD;
            rdch_d = cs_now[1];
            sh_d = {7'h00, 1'b1, code_all[cs_now[1]], fa_q[cs_now[1]]};
            oe_n_d = 1'b0;
          end else begin
            st_d = GSRC_SER_WR;
          end
        end
      end
      GSRC_SER_WR: begin
        if (sclk_rise && bits_q <= `GSRC_SPI_BITS) begin
          sh_d = {sh_q[14:0], sdi_s};
          bits_d = bits_q + 5'h01;
        end
        if (!serial_mode) begin
          st_d = GSRC_SER_IDLE;
        end else if (cs_now == 2'b00) begin
          st_d = GSRC_SER_IDLE;
          // a short or long frame is dropped whole
          if (bits_q == `GSRC_SPI_BITS) begin
            for (int c = 0; c < 2; c++) begin
              if (chsel_q[c]) begin
                if (sh_q[`GSRC_SPI_RW_BIT]) begin
                  armed_d[c] = 1'b1;
                end else begin
                  ser_wr[c] = 1'b1;
                  fa_d[c] = sh_q[`GSRC_SPI_FA_MSB:0];
                  armed_d[c] = 1'b0;
                end
              end
            end
          end
        end
      end
      GSRC_SER_RD: begin
        if (sclk_rise) begin
          sdo_d = sh_q[15];
          sh_d = {sh_q[14:0], 1'b0};
        end
        if (!serial_mode || cs_now == 2'b00) begin
          st_d = GSRC_SER_IDLE;
          armed_d[rdch_q] = 1'b0;
          oe_n_d = 1'b1;
        end
      end
      default: begin
        st_d = GSRC_SER_IDLE;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= GSRC_SER_IDLE;
      bits_q <= 5'h00;
      sh_q <= 16'h0000;
      chsel_q <= 2'b00;
      rdch_q <= 1'b0;
      armed_q <= 2'b00;
      fa_q <= '0;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      chsel_q <= chsel_d;
      rdch_q <= rdch_d;
      armed_q <= armed_d;
      fa_q <= fa_d;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_serial_data = sdo_q;
  assign o_serial_data_oe_n = oe_n_q;

  // wishbone slave, one wait state; a write lands at the edge where ack is seen
  logic [1:0] seen_q, seen_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] wadr;

  assign wadr = {i_wb_adr[7:2], 2'b00};

  always_comb begin
    ack_d = i_wb_cyc & i_wb_stb & ~ack_q;
    step_en_d = step_en_q;
    seen_d = seen_q;
    rdat_d = rdat_q;
    if (ack_q && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]) begin
      if (wadr == `GSRC_REG_CTRL) begin
        step_en_d = i_wb_dat[1:0];
      end
      if (wadr == `GSRC_REG_STATUS) begin
        seen_d = seen_q & ~i_wb_dat[1:0];
      end
    end
    // a reset seen in the clearing cycle survives the clear
    seen_d = seen_d | rst_evt;
    if (ack_d) begin
      rdat_d = 32'h0000_0000;
      if (!i_wb_we) begin
        unique case (wadr)
          `GSRC_REG_CTRL: rdat_d[1:0] = step_en_q;
          `GSRC_REG_STATUS: begin
            rdat_d[1:0] = seen_q;
            rdat_d[`GSRC_ST_ARMED_LSB+:2] = armed_q;
            rdat_d[`GSRC_ST_MODE_LSB+:2] = {md_hi_s, md_lo_s};
          end
          `GSRC_REG_GAIN_A: begin
            rdat_d[5:0] = code_all[0];
            rdat_d[`GSRC_GAIN_DB_LSB+:8] = db_all[0];
          end
          `GSRC_REG_GAIN_B: begin
            rdat_d[5:0] = code_all[1];
            rdat_d[`GSRC_GAIN_DB_LSB+:8] = db_all[1];
          end
          default: rdat_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      step_en_q <= `GSRC_CTRL_RESET;
      seen_q <= 2'b00;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      step_en_q <= step_en_d;
      seen_q <= seen_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
endmodule

/* testbench/gsrc_checker.sv */
// port checker for the gain step block, bound to its top module
// assumes pin inputs move slowly against i_clk
`timescale 1ns/1ps
module gsrc_checker (
  input wire logic i_clk, // clock
  input wire logic i_rst, // reset
  input wire logic i_wb_cyc, // cycle
  input wire logic i_wb_stb, // strobe
  input wire logic i_wb_we, // write
  input wire logic [1:0] i_step_pulse_clock, // pulses
  input wire logic i_step_size_select_hi, // size hi
  input wire logic i_step_size_select_lo, // size lo
  input wire logic i_iface_select_hi, // mode hi
  input wire logic i_iface_select_lo, // mode lo
  input wire logic i_chan_a_select_n, // select a
  input wire logic i_chan_b_select_n, // select b
  input wire logic i_serial_clock, // serial clock
  input wire logic o_serial_data, // data out
  input wire logic o_serial_data_oe_n, // drive enable
  input wire logic o_wb_ack, // ack
  input wire logic [5:0] o_gain_code_a, // code a
  input wire logic [5:0] o_gain_code_b, // code b
  input wire logic [7:0] o_gain_db_a // db a
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  function automatic logic [7:0] dbf(logic [5:0] c);
    return (c > 6'h23) ? 8'hF7 : 8'h1A - {2'h0, c};
  endfunction
  // int arithmetic so that a wrapped step cannot pass for a legal one
  function automatic logic ok_step(logic [5:0] o, logic [5:0] n, int s);
    return n == 6'h3F || int'(n) == int'(o) + s || int'(n) == int'(o) - s
      || (n == 6'h00 && int'(o) < s);
  endfunction
  property p_ack_resp; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_db_map; $stable(o_gain_code_a) |-> o_gain_db_a == dbf(o_gain_code_a); endproperty
  a_db_map: assert property (p_db_map) else $error("gain db wrong");
  property p_oe_mode; (i_iface_select_hi || !i_iface_select_lo)[*5] |-> o_serial_data_oe_n;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("drive outside serial");
  property p_oe_sel; (i_chan_a_select_n && i_chan_b_select_n)[*5] |-> o_serial_data_oe_n;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("drive outside frame");
  property p_data_hold; (!i_serial_clock && !o_serial_data_oe_n)[*4] |-> $stable(o_serial_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_step; $changed(o_gain_code_a) && i_iface_select_hi |-> ok_step($past(o_gain_code_a),
    o_gain_code_a, 1 << {i_step_size_select_hi, i_step_size_select_lo}); endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_indep; (i_iface_select_hi && !i_wb_we && $stable(i_step_pulse_clock[1]))[*8]
    |-> $stable(o_gain_code_b); endproperty
  a_indep: assert property (p_indep) else $error("code b moved");
endmodule
bind gsrc_top gsrc_checker u_chk (.*);

/* testbench/gsrc_host.sv */
// host controller model driving step pins and serial frames
// assumes i_line is the resolved data wire; pins move just after i_clk rises
`timescale 1ns/1ps
module gsrc_host (
  input wire logic i_clk, // clock
  input wire logic i_line, // data wire
  output logic [1:0] o_pulse, // step pulses
  output logic [1:0] o_dir, // directions
  output logic o_sel_a_n, // select a
  output logic o_sel_b_n, // select b
  output logic o_sclk, // serial clock
  output logic o_sd // driven data
);
  initial begin
    {o_pulse, o_dir, o_sel_a_n, o_sel_b_n, o_sclk, o_sd} = 8'h0C;
  end
  task automatic wt(int n);
    repeat (n) @(posedge i_clk);
  endtask
  // each level held 32 ns or more, well over the three-clock minimum
  task automatic step(int ch, logic d, logic flip);
    o_dir[ch] <= d;
    wt(4);
    o_pulse[ch] <= 1'h1;
    wt(4);
    if (flip) begin
      o_dir[ch] <= !d;
    end
    wt(4);
    o_pulse[ch] <= 1'h0;
    wt(8);
  endtask
  task automatic frame(logic [1:0] sel_n, logic [15:0] w, output logic [15:0] r);
    {o_sel_b_n, o_sel_a_n} <= sel_n;
    wt(12);
    for (int i = 15; i >= 0; i--) begin
      o_sd <= w[i];
      wt(4);
      o_sclk <= 1'h1;
      wt(4);
      o_sclk <= 1'h0;
      r[i] = i_line;
    end
    {o_sel_b_n, o_sel_a_n} <= 2'h3;
    o_sd <= !o_sd;
    wt(8);
  endtask
endmodule

/* testbench/gsrc_top_test.sv */
// self-checking bench for the gain step block
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
module gsrc_top_test;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, drv = 0;
  logic [7:0] adr = 8'h00, db_a, db_b;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [1:0] mode = 2'h2, gs = 2'h0, pulse, dir;
  logic sa_n, sb_n, sclk, hsd, dsd, oe_n, line;
  logic [5:0] code_a, code_b;
  int n_mismatch = 0, num_checks = 0;
  always #4 clk = !clk;
  assign line = oe_n ? hsd : dsd;
  always @(posedge clk) if (!oe_n) drv <= 1'h1;
  gsrc_top DUT (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_step_pulse_clock(pulse), .i_step_direction(dir), .i_step_size_select_hi(gs[1]),
    .i_step_size_select_lo(gs[0]), .i_iface_select_hi(mode[1]), .i_iface_select_lo(mode[0]),
    .i_chan_a_select_n(sa_n), .i_chan_b_select_n(sb_n), .i_serial_clock(sclk),
    .i_serial_data(line), .o_serial_data(dsd), .o_serial_data_oe_n(oe_n),
    .o_gain_code_a(code_a), .o_gain_code_b(code_b), .o_gain_db_a(db_a), .o_gain_db_b(db_b));
  gsrc_host host (.i_clk(clk), .i_line(line), .o_pulse(pulse), .o_dir(dir),
    .o_sel_a_n(sa_n), .o_sel_b_n(sb_n), .o_sclk(sclk), .o_sd(hsd));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    int n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) chk(0, 1);
    @(posedge clk);
  endtask
  function automatic logic [7:0] exp_db(logic [5:0] c);
    return (c > 6'h23) ? 8'hF7 : 8'h1A - {2'h0, c};
  endfunction
  task automatic chk_a(logic [5:0] c);
    logic [31:0] r;
    wb(0, 8'h08, 0, r);
    chk({26'h0, code_a}, {26'h0, c});
    chk({24'h0, db_a}, {24'h0, exp_db(c)});
    chk(r, {16'h0, exp_db(c), 2'h0, c});
  endtask
  task automatic t_reset();
    logic [31:0] r;
    wb(1, 8'h20, 32'hFFFF_FFFF, r);
    wb(0, 8'h20, 0, r);
    chk(r, 32'h0000_0000);
    wb(0, 8'h00, 0, r);
    chk(r, 32'h0000_0003);
    chk_a(6'h3F);
  endtask
  task automatic t_step();
    logic [5:0] c = 6'h3F;
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      gs <= 2'(k);
      host.step(0, 0, 0);
      c = c - (6'h01 << k);
      chk_a(c);
    end
    repeat (7) host.step(0, 0, 0);
    chk_a(6'h00);
    chk({26'h0, code_b}, 32'h0000_003F);
    host.step(0, 1, 0);
    chk_a(6'h08);
    host.step(0, 1, 1);
    chk_a(6'h3F);
    wb(0, 8'h04, 0, r);
    chk(r & 32'h0000_0003, 32'h0000_0001);
    wb(1, 8'h04, 32'h0000_0001, r);
    wb(0, 8'h04, 0, r);
    chk(r & 32'h0000_0003, 32'h0000_0000);
    mode <= 2'h3;
    host.step(0, 1, 0);
    chk_a(6'h3F);
    host.step(1, 0, 0);
    chk({26'h0, code_b}, 32'h0000_0037);
    chk({24'h0, db_b}, {24'h0, exp_db(6'h37)});
    wb(1, 8'h00, 32'h0000_0001, r);
    host.step(1, 0, 0);
    chk({26'h0, code_b}, 32'h0000_0037);
    wb(1, 8'h00, 32'h0000_0003, r);
  endtask
  task automatic t_serial();
    logic [15:0] q;
    logic [31:0] r;
    mode <= 2'h1;
    host.frame(2'h0, 16'h0054, q);
    chk_a(6'h15);
    chk({26'h0, code_b}, 32'h0000_0015);
    chk({24'h0, db_b}, {24'h0, exp_db(6'h15)});
    wb(0, 8'h0C, 0, r);
    chk(r, {16'h0, exp_db(6'h15), 2'h0, 6'h15});
    host.frame(2'h2, 16'h0100, q);
    wb(0, 8'h04, 0, r);
    chk(r & 32'h0000_0300, 32'h0000_0100);
    host.frame(2'h2, 16'h0000, q);
    chk({16'h0, q}, 32'h0000_0154);
    drv = 0;
    host.frame(2'h2, 16'h0000, q);
    chk({31'h0, drv}, 32'h0);
    chk_a(6'h00);
    host.frame(2'h1, 16'h0100, q);
    host.frame(2'h1, 16'h0000, q);
    chk({16'h0, q}, 32'h0000_0154);
    host.frame(2'h1, 16'h0100, q);
    mode <= 2'h2;
    drv = 0;
    host.frame(2'h1, 16'h0000, q);
    chk({31'h0, drv}, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    t_reset();
    t_step();
    t_serial();
    conclude();
  end
  // the whole run needs about 13 us
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
